// ==== logic/ascsc_buf.sv ====
// small valid/ready buffer for conversion results
`timescale 1ns/1ps
module ascsc_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  // handshakes
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ==== logic/ascsc_ctrl.sv ====
// serial command port and sampling sequencer of the converter
//
// Overview of operation
// - after reset done output is high and input shift register is zero
// - two all-ones frames of 16 clocks load hardware default
// - hardware default loads configuration 800h
// - chip-select fall with frame sync high starts the cycle
// - chip select high: output off, input ignored, clock still paces sampling and serial-clock conversion
// - chip-select fall with frame sync low arms frame-sync rise start
// - msb captured on first falling clock, output msb valid before it
// - later output bits change on rising clock, inputs on falling
// - after 16 bits or chip-select rise, output off, input ignored
// - output word is last result, or fifo head in fifo modes
// - first four clocks carry the command nibble
// - decode select, config write, fifo read, sleep, hardware default
// - config write stores twelve following bits, others discard them
// - clock may pause after eight bits, shifting resumes later
// - trailing output bits valid only for select and fifo read
// - short sampling lasts 12 clocks then converts by itself
// - sampling starts after fourth falling clock for select codes only
// - long sampling lasts 44 clocks
// - extended sampling follows conversion-start low, converts 15 ns later
// - extended mode entered on fall, left after two starts
// - conversion is 18 conversion clocks plus 15 ns
// - end-of-conversion low while converting, interrupt low at end
`timescale 1ns/1ps
module ascsc_ctrl
  import ascsc_pkg::*;
#(
  parameter int OSC_DIV = 4
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // serial pins
  input  wire logic        cs_n_i,
  input  wire logic        frame_sync_in_i,
  input  wire logic        sclk_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  // trigger and done pins
  input  wire logic        conv_start_n_i,
  output logic             done_n_o,
  // conversion engine
  output logic             sampling_o,
  output logic             conv_start_o,
  output logic             conv_busy_o,
  output logic [3:0]       channel_o,
  input  wire logic        result_valid_i,
  input  wire logic [15:0] result_data_i,
  output logic             result_ready_o,
  // result fifo
  input  wire logic [15:0] fifo_head_i,
  output logic             fifo_pop_o,
  // status
  output logic [11:0]      config_reg_o,
  output logic             sleep_o,
  output logic             ext_mode_o,
  output logic             hw_default_o,
  output logic             frame_active_o
);

  logic [NPINS-1:0] pins_meta_reg;
  logic [NPINS-1:0] pins_sync_reg;
  logic [NPINS-1:0] pins_prev_reg;
  logic cs_n;
  logic fs;
  logic serial_in;
  logic cst_n;
  logic cs_fall;
  logic cs_rise;
  logic fs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic cst_fall;
  logic cst_rise;
  logic start;
  logic arm_fs_reg;
  logic active_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] in_shift_reg;
  logic [15:0] out_shift_reg;
  logic [15:0] last_result_reg;
  logic [3:0] cmd_reg;
  logic [3:0] cmd_next;
  logic [15:0] rx_word;
  logic cmd_edge;
  logic word_edge;
  logic is_select;
  logic fifo_mode;
  logic [11:0] config_reg;
  logic [1:0] hwdef_cnt_reg;
  logic hw_default_reg;
  logic sleep_reg;
  logic fifo_pop_reg;
  logic ext_mode_reg;
  logic ext_armed_reg;
  ascsc_phase_t phase_reg;
  logic [5:0] samp_cnt_reg;
  logic [5:0] samp_len;
  logic [4:0] conv_cnt_reg;
  logic [1:0] sclk_div_reg;
  logic [3:0] dly_cnt_reg;
  logic [$clog2(OSC_DIV+1)-1:0] osc_cnt_reg;
  logic osc_en;
  logic conv_tick;
  logic conv_start_reg;
  logic conv_end;
  logic done_n_reg;
  logic buf_valid;
  logic [15:0] buf_data;

  // two-stage synchronisers for every pin
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          pins_meta_reg[gi] <= PIN_IDLE[gi];
          pins_sync_reg[gi] <= PIN_IDLE[gi];
          pins_prev_reg[gi] <= PIN_IDLE[gi];
        end else begin
          pins_meta_reg[gi] <= gi == PIN_SCLK ? sclk_i :
                               gi == PIN_CS   ? cs_n_i :
                               gi == PIN_FS   ? frame_sync_in_i :
                               gi == PIN_SDI  ? serial_in_i :
                                                conv_start_n_i;
          pins_sync_reg[gi] <= pins_meta_reg[gi];
          pins_prev_reg[gi] <= pins_sync_reg[gi];
        end
      end
    end
  endgenerate

  // pin levels and edges
  assign cs_n  = pins_sync_reg[PIN_CS];
  assign fs    = pins_sync_reg[PIN_FS];
  assign serial_in   = pins_sync_reg[PIN_SDI];
  assign cst_n = pins_sync_reg[PIN_CST];
  assign cs_fall   = pins_prev_reg[PIN_CS] & ~cs_n;
  assign cs_rise   = ~pins_prev_reg[PIN_CS] & cs_n;
  assign fs_rise   = ~pins_prev_reg[PIN_FS] & fs;
  assign sclk_fall = pins_prev_reg[PIN_SCLK] & ~pins_sync_reg[PIN_SCLK];
  assign sclk_rise = ~pins_prev_reg[PIN_SCLK] & pins_sync_reg[PIN_SCLK];
  assign cst_fall  = pins_prev_reg[PIN_CST] & ~cst_n;
  assign cst_rise  = ~pins_prev_reg[PIN_CST] & cst_n;

  // start on chip-select fall with frame sync high, or on armed frame-sync rise
  assign start = (cs_fall & fs) | (arm_fs_reg & fs_rise & ~cs_n);

  // frame-sync start arming
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      arm_fs_reg <= 1'b0;
    end else if (cs_rise || start) begin
      arm_fs_reg <= 1'b0;
    end else if (cs_fall && !fs) begin
      arm_fs_reg <= 1'b1;
    end
  end

  // word framing events
  assign cmd_edge  = active_reg & sclk_fall & (bit_cnt_reg == CMD_LAST_BIT);
  assign word_edge = active_reg & sclk_fall & (bit_cnt_reg == WORD_LAST_BIT);
  assign cmd_next  = {in_shift_reg[2:0], serial_in};
  assign rx_word   = {in_shift_reg[14:0], serial_in};

  // frame closes at 16 bits or chip-select rise
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      active_reg  <= 1'b0;
      bit_cnt_reg <= '0;
    end else if (start) begin
      active_reg  <= 1'b1;
      bit_cnt_reg <= '0;
    end else if (cs_rise || word_edge) begin
      active_reg <= 1'b0;
    end else if (active_reg && sclk_fall) begin
      // counter simply waits while the clock pauses
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // input bits captured on falling clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      in_shift_reg <= '0;
    end else if (active_reg && sclk_fall && !cs_n) begin
      in_shift_reg <= rx_word;
    end
  end

  // fifo head in fifo modes, else last result
  assign fifo_mode = config_reg[CFG_MODE_LSB+1:CFG_MODE_LSB] != 2'h0;

  // msb loaded at start, valid before first fall
  // following bits change on rising clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      out_shift_reg <= '0;
    end else if (start) begin
      out_shift_reg <= fifo_mode ? fifo_head_i : last_result_reg;
    end else if (active_reg && sclk_rise && bit_cnt_reg != 5'h00) begin
      out_shift_reg <= {out_shift_reg[14:0], 1'b0};
    end
  end

  // output driven only inside an open frame
  // trailing bits meaningful only for select and fifo read
  assign serial_out_o    = out_shift_reg[WORD_BITS-1];
  assign serial_out_oe_o = active_reg;

  // command nibble latched on fourth falling clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd_reg <= '0;
    end else if (cmd_edge) begin
      cmd_reg <= cmd_next;
    end
  end

  // select covers every code not otherwise decoded
  assign is_select = (cmd_next != CMD_CFG_WRITE) &&
                     (cmd_next != CMD_FIFO_READ) &&
                     (cmd_next != CMD_SOFT_SLEEP) &&
                     (cmd_next != CMD_HW_DEFAULT);

  // configuration written by a config write or by hardware default
  // two all-ones frames in a row
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      config_reg     <= CFG_RESET;
      hwdef_cnt_reg  <= '0;
      hw_default_reg <= 1'b0;
    end else if (word_edge) begin
      if (rx_word == ALL_ONES_WORD) begin
        if (hwdef_cnt_reg + 2'h1 >= HWDEF_CYCLES || hw_default_reg) begin
          config_reg     <= CFG_HW_DEF;
          hw_default_reg <= 1'b1;
        end
        hwdef_cnt_reg <= hwdef_cnt_reg + 2'h1;
      end else begin
        hwdef_cnt_reg <= '0;
        if (cmd_reg == CMD_CFG_WRITE) begin
          config_reg <= rx_word[CFG_BITS-1:0];
        end
      end
    end else if (cs_rise && active_reg) begin
      hwdef_cnt_reg <= '0;
    end
  end

  // software sleep and fifo read effects
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sleep_reg    <= 1'b0;
      fifo_pop_reg <= 1'b0;
    end else begin
      fifo_pop_reg <= word_edge & fifo_mode & (cmd_reg == CMD_FIFO_READ);
      if (word_edge && cmd_reg == CMD_SOFT_SLEEP) begin
        sleep_reg <= 1'b1;
      end else if (start) begin
        sleep_reg <= 1'b0;
      end
    end
  end

  // extended mode entry and two-start exit
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ext_mode_reg  <= 1'b0;
      ext_armed_reg <= 1'b0;
    end else if (cst_fall) begin
      ext_mode_reg  <= 1'b1;
      ext_armed_reg <= 1'b0;
    end else if (start && ext_mode_reg && cst_n) begin
      if (ext_armed_reg) begin
        ext_mode_reg  <= 1'b0;
        ext_armed_reg <= 1'b0;
      end else begin
        ext_armed_reg <= 1'b1;
      end
    end
  end

  assign samp_len = config_reg[CFG_SHORT_BIT] ? SAMPLE_SHORT_LEN
                                              : SAMPLE_LONG_LEN;

  // internal oscillator as an enable pulse
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      osc_cnt_reg <= '0;
    end else if (osc_en) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 1'b1;
    end
  end
  assign osc_en = osc_cnt_reg == ($clog2(OSC_DIV+1))'(OSC_DIV - 1);

  // conversion clock is oscillator or serial clock over four
  assign conv_tick = config_reg[CFG_SCLK_CONV_BIT]
                     ? (sclk_rise && sclk_div_reg == SCLK_DIV_LAST)
                     : osc_en;
  assign conv_end  = (phase_reg == PH_TAIL) && (dly_cnt_reg == CONV_DLY_LAST);

  // sampling and conversion sequencer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phase_reg      <= PH_IDLE;
      samp_cnt_reg   <= '0;
      conv_cnt_reg   <= '0;
      sclk_div_reg   <= '0;
      dly_cnt_reg    <= '0;
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= 1'b0;
      case (phase_reg)
        PH_IDLE: begin
          if (cst_fall) begin
            phase_reg <= PH_EXT_SAMPLE;
          end else if (cmd_edge && is_select && !ext_mode_reg) begin
            // normal sampling after fourth falling clock
            phase_reg    <= PH_SAMPLE;
            samp_cnt_reg <= '0;
          end
        end
        PH_SAMPLE: begin
          if (sclk_fall) begin
            samp_cnt_reg <= samp_cnt_reg + 6'h01;
            if (samp_cnt_reg == samp_len - 6'h01) begin
              phase_reg      <= PH_CONV;
              conv_cnt_reg   <= '0;
              sclk_div_reg   <= '0;
              conv_start_reg <= 1'b1;
            end
          end
        end
        PH_EXT_SAMPLE: begin
          if (cst_rise) begin
            phase_reg   <= PH_DLY;
            dly_cnt_reg <= '0;
          end
        end
        PH_DLY: begin
          dly_cnt_reg <= dly_cnt_reg + 4'h1;
          if (dly_cnt_reg == CONV_DLY_LAST) begin
            phase_reg      <= PH_CONV;
            conv_cnt_reg   <= '0;
            sclk_div_reg   <= '0;
            conv_start_reg <= 1'b1;
          end
        end
        PH_CONV: begin
          if (sclk_rise) begin
            sclk_div_reg <= sclk_div_reg + 2'h1;
          end
          if (conv_tick) begin
            conv_cnt_reg <= conv_cnt_reg + 5'h01;
            // 18 conversion clocks then 15 ns
            if (conv_cnt_reg == CONV_CLKS - 5'h01) begin
              phase_reg   <= PH_TAIL;
              dly_cnt_reg <= '0;
            end
          end
        end
        PH_TAIL: begin
          dly_cnt_reg <= dly_cnt_reg + 4'h1;
          if (dly_cnt_reg == CONV_DLY_LAST) begin
            phase_reg <= PH_IDLE;
          end
        end
        default: begin
          phase_reg <= PH_IDLE;
        end
      endcase
    end
  end

  // channel taken from the select command
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      channel_o <= '0;
    end else if (cmd_edge && is_select) begin
      channel_o <= cmd_next;
    end
  end

  // low during conversion, or low at end in interrupt use
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      done_n_reg <= 1'b1;
    end else if (config_reg[CFG_EOC_SEL_BIT]) begin
      if (conv_start_reg) begin
        done_n_reg <= 1'b0;
      end else if (conv_end) begin
        done_n_reg <= 1'b1;
      end
    end else if (conv_end) begin
      done_n_reg <= 1'b0;
    end else if (start) begin
      done_n_reg <= 1'b1;
    end
  end

  // results wait in the buffer while a frame shifts out
  ascsc_buf #(
    .W     (WORD_BITS),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (result_valid_i),
    .in_data_i   (result_data_i),
    .in_ready_o  (result_ready_o),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (~active_reg)
  );

  // first result after reset is not meaningful to the host
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      last_result_reg <= '0;
    end else if (buf_valid && !active_reg) begin
      last_result_reg <= buf_data;
    end
  end

  // status outputs
  assign done_n_o       = done_n_reg;
  assign sampling_o     = (phase_reg == PH_SAMPLE) ||
                          (phase_reg == PH_EXT_SAMPLE);
  assign conv_start_o   = conv_start_reg;
  assign conv_busy_o    = (phase_reg == PH_CONV) || (phase_reg == PH_TAIL);
  assign fifo_pop_o     = fifo_pop_reg;
  assign config_reg_o   = config_reg;
  assign sleep_o        = sleep_reg;
  assign ext_mode_o     = ext_mode_reg;
  assign hw_default_o   = hw_default_reg;
  assign frame_active_o = active_reg;

endmodule

// ==== pkg/ascsc_pkg.sv ====
// constants and types shared by the serial command and sampling controller
package ascsc_pkg;

  // clock and analog delay timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_DLY_NS   = 15;
  localparam int CONV_DLY_CYC  =
    (CONV_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CONV_DLY_LAST = 4'(CONV_DLY_CYC - 1);

  // serial word layout
  localparam int WORD_BITS = 16;
  localparam int CMD_BITS  = 4;
  localparam int CFG_BITS  = 12;
  localparam logic [4:0] CMD_LAST_BIT  = 5'h03;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0f;

  // sampling and conversion lengths
  localparam logic [5:0] SAMPLE_SHORT_LEN = 6'h0c;
  localparam logic [5:0] SAMPLE_LONG_LEN  = 6'h2c;
  localparam logic [4:0] CONV_CLKS        = 5'h12;
  localparam logic [1:0] SCLK_DIV_LAST    = 2'h3;

  // power-up default sequence
  localparam logic [1:0] HWDEF_CYCLES = 2'h2;
  localparam logic [15:0] ALL_ONES_WORD = 16'hffff;

  // configuration register
  localparam logic [11:0] CFG_RESET   = 12'h000;
  localparam logic [11:0] CFG_HW_DEF  = 12'h800;
  localparam int CFG_EOC_SEL_BIT      = 10;
  localparam int CFG_SHORT_BIT        = 9;
  localparam int CFG_SCLK_CONV_BIT    = 8;
  localparam int CFG_MODE_LSB         = 5;

  // command codes
  localparam logic [3:0] CMD_CFG_WRITE  = 4'ha;
  localparam logic [3:0] CMD_FIFO_READ  = 4'he;
  localparam logic [3:0] CMD_SOFT_SLEEP = 4'h8;
  localparam logic [3:0] CMD_HW_DEFAULT = 4'hf;
  localparam logic [3:0] CMD_RSVD_B     = 4'hb;

  // synchronised pin vector
  localparam int PIN_CS   = 0;
  localparam int PIN_FS   = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDI  = 3;
  localparam int PIN_CST  = 4;
  localparam int NPINS    = 5;
  localparam logic [4:0] PIN_IDLE = 5'h17;

  // sequencer phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SAMPLE,
    PH_EXT_SAMPLE,
    PH_DLY,
    PH_CONV,
    PH_TAIL
  } ascsc_phase_t;

endpackage

// ==== verification/ascsc_ctrl_asserts.sv ====
// port assertions for the serial command and sampling controller
`timescale 1ns/1ps
module ascsc_ctrl_asserts #(
  parameter int OSC_DIV = 4
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // pins
  input wire logic        cs_n_i,
  input wire logic        conv_start_n_i,
  input wire logic        serial_out_oe_o,
  input wire logic        done_n_o,
  // sequencer status
  input wire logic        sampling_o,
  input wire logic        conv_start_o,
  input wire logic        conv_busy_o,
  input wire logic        ext_mode_o,
  input wire logic        frame_active_o,
  input wire logic [11:0] config_reg_o
);
  localparam int BLO = 17 * OSC_DIV + 2;
  localparam int BHI = 18 * OSC_DIV + 4;
  int bc;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // busy length counter
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !conv_busy_o) bc <= 0;
    else bc <= bc + 1;
  end
  sequence s_ext_rel;
    ext_mode_o && sampling_o && $rose(conv_start_n_i);
  endsequence
  property p_rst_state;
    $rose(rstn_i) |-> done_n_o && !serial_out_oe_o && config_reg_o == 12'h000;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("bad state after reset");
  property p_idle_off;
    cs_n_i [*6] |-> !serial_out_oe_o;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("output driven while deselected");
  property p_oe_start;
    $rose(serial_out_oe_o) |-> !cs_n_i && !$past(cs_n_i, 3);
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("output enabled without select");
  property p_cfg_frame;
    $changed(config_reg_o) |-> $past(frame_active_o);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame)
    else $error("config changed outside frame");
  property p_conv_go;
    conv_start_o |-> !$past(conv_busy_o) ##1 conv_busy_o [*4];
  endproperty
  a_conv_go: assert property (p_conv_go)
    else $error("conversion start misbehaved");
  property p_busy_len;
    $fell(conv_busy_o) && !config_reg_o[8] |-> bc >= BLO && bc <= BHI;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("conversion length wrong");
  property p_eoc_low;
    conv_start_o && config_reg_o[10] |-> ##[1:2] !done_n_o;
  endproperty
  a_eoc_low: assert property (p_eoc_low)
    else $error("end flag not low in conversion");
  property p_int_low;
    $fell(conv_busy_o) && !config_reg_o[10] |-> ##[0:3] !done_n_o;
  endproperty
  a_int_low: assert property (p_int_low)
    else $error("interrupt missing at end");
  property p_ext_conv;
    s_ext_rel |-> ##[3:7] conv_start_o;
  endproperty
  a_ext_conv: assert property (p_ext_conv)
    else $error("no conversion after trigger release");
endmodule

// ==== verification/ascsc_ctrl_tb.sv ====
// self-checking bench for the serial command and sampling controller
`timescale 1ns/1ps
module ascsc_ctrl_tb;
  localparam int ODIV = 2;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cs_n, fs, sclk, serial_in, cst_n, so, oe, done_n, smp, cgo, busy;
  logic        rv;
  logic        rr, pop, slp, ext, hwd, act;
  logic [3:0]  chan;
  logic [11:0] cfg;
  logic [15:0] rd;
  logic [15:0] fh;
  logic [15:0] rx;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_conv = 0;
  int          n_pop = 0;
  int          conv_at = 0;
  int          smp_at = 0;
  int          cyc = 0;
  always #5 clk_i = ~clk_i;
  ascsc_host host (.clk_i(clk_i), .serial_out_i(so), .cs_n_o(cs_n),
    .frame_sync_o(fs), .sclk_o(sclk), .serial_in_o(serial_in),
    .conv_start_n_o(cst_n));
  ascsc_ctrl #(.OSC_DIV(ODIV)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .cs_n_i(cs_n), .frame_sync_in_i(fs), .sclk_i(sclk), .serial_in_i(serial_in),
    .serial_out_o(so), .serial_out_oe_o(oe), .conv_start_n_i(cst_n),
    .done_n_o(done_n), .sampling_o(smp), .conv_start_o(cgo),
    .conv_busy_o(busy), .channel_o(chan), .result_valid_i(rv),
    .result_data_i(rd), .result_ready_o(rr), .fifo_head_i(fh),
    .fifo_pop_o(pop), .config_reg_o(cfg), .sleep_o(slp), .ext_mode_o(ext),
    .hw_default_o(hwd), .frame_active_o(act));
  // event log and timeout
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cgo === 1'b1) begin
      n_conv <= n_conv + 1;
      conv_at <= host.nf;
    end
    if (smp === 1'b1 && smp_at == 0) smp_at <= host.nf;
    if (pop === 1'b1) n_pop <= n_pop + 1;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chkb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  // hand one result to the buffer
  task automatic push(input logic [15:0] d);
    @(negedge clk_i);
    rv = 1'b1;
    rd = d;
    do @(posedge clk_i); while (rr !== 1'b1);
    @(negedge clk_i);
    rv = 1'b0;
  endtask
  // wait for conversion to finish, bounded
  task automatic settle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(negedge clk_i);
      k++;
    end
    // a conversion that never ends is a mismatch
    if (busy !== 1'b0) begin
      n_errors++;
      $display("unexpected at %0t: conversion never ended", $time);
    end
    host.wt(5);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rv = 1'b0;
    rd = 16'h0000;
    fh = 16'hc3c3;
    host.wt(10);
    rstn_i = 1'b1;
    host.wt(4);
    chkb(done_n, 1'b1);
    chkb(oe, 1'b0);
    // first result is dropped by host
    push(16'h1234);
    host.frame(16'hffff, 16, 0, 16, rx);
    host.frame(16'hffff, 16, 0, 16, rx);
    chkw({4'h0, cfg}, 16'h0800);
    chkb(hwd, 1'b1);
    push(16'h5a3c);
    smp_at = 0;
    host.frame(16'h1000, 48, 0, 48, rx);
    chkw(rx, 16'h5a3c);
    chkw(16'(smp_at), 16'h0004);
    chkw(16'(conv_at), 16'h0030);
    settle;
    chkb(done_n, 1'b0);
    host.frame(16'ha000, 16, 0, 16, rx);
    smp_at = 0;
    host.frame(16'ha600, 16, 0, 16, rx);
    chkw({4'h0, cfg}, 16'h0600);
    chkw(16'(smp_at), 16'h0000);
    chkw(16'(n_conv), 16'h0001);
    chkb(done_n, 1'b1);
    push(16'h0f0f);
    host.frame(16'h3000, 16, 1, 16, rx);
    chkw(rx, 16'h0f0f);
    chkw(16'(conv_at), 16'h0010);
    chkw({12'h000, chan}, 16'h0003);
    chkb(done_n, 1'b0);
    settle;
    chkb(done_n, 1'b1);
    host.frame(16'h8abc, 16, 0, 16, rx);
    chkb(slp, 1'b1);
    chkw({4'h0, cfg}, 16'h0600);
    host.frame(16'h2000, 16, 0, 3, rx);
    chkb(act, 1'b0);
    chkw(16'(n_conv), 16'h0002);
    host.trig(1'b0);
    chkb(ext, 1'b1);
    chkb(smp, 1'b1);
    host.trig(1'b1);
    chkw(16'(n_conv), 16'h0003);
    settle;
    host.frame(16'h1000, 16, 0, 16, rx);
    chkw(16'(n_conv), 16'h0003);
    host.frame(16'h1000, 16, 0, 16, rx);
    chkb(ext, 1'b0);
    settle;
    // fifo mode: head word shifted out, read frame pops it
    host.frame(16'ha620, 16, 0, 16, rx);
    fh = 16'h9a5e;
    host.frame(16'he000, 16, 0, 16, rx);
    chkw(rx, 16'h9a5e);
    chkw(16'(n_pop), 16'h0001);
    final_report();
  end
endmodule
bind ascsc_ctrl ascsc_ctrl_asserts #(.OSC_DIV(OSC_DIV)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .conv_start_n_i(conv_start_n_i), .serial_out_oe_o(serial_out_oe_o),
  .done_n_o(done_n_o), .sampling_o(sampling_o),
  .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o),
  .ext_mode_o(ext_mode_o), .frame_active_o(frame_active_o),
  .config_reg_o(config_reg_o));

// ==== verification/ascsc_host.sv ====
// host serial master and trigger model
`timescale 1ns/1ps
module ascsc_host (
  // clock
  input  wire logic clk_i,
  // device pins
  input  wire logic serial_out_i,
  output logic      cs_n_o,
  output logic      frame_sync_o,
  output logic      sclk_o,
  output logic      serial_in_o,
  output logic      conv_start_n_o
);
  int nf;  // serial clock falls in this frame
  // idle pin levels
  initial begin
    cs_n_o = 1'b1;
    frame_sync_o = 1'b1;
    sclk_o = 1'b1;
    serial_in_o = 1'b0;
    conv_start_n_o = 1'b1;
    nf = 0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one frame; cut closes it early
  task automatic frame(input logic [15:0] w, input int n, input bit fsm,
                       input int cut, output logic [15:0] rx);
    rx = 16'h0000;
    nf = 0;
    frame_sync_o = !fsm;
    cs_n_o = 1'b0;
    if (fsm) begin
      wt(4);
      frame_sync_o = 1'b1;
    end
    wt(6);
    for (int i = 0; i < n && i < cut; i++) begin
      if (i == 8) wt(20);
      if (i < 16) serial_in_o = w[15-i];
      wt(2);
      if (i < 16) rx[15-i] = serial_out_i;
      sclk_o = 1'b0;
      nf++;
      wt(5);
      sclk_o = 1'b1;
      wt(3);
    end
    cs_n_o = 1'b1;
    serial_in_o = !serial_in_o;  // released line shows no stale bit
    wt(8);
  endtask
  task automatic trig(input logic v);
    conv_start_n_o = v;
    wt(8);
  endtask
endmodule
